// >>> hw/lfs_params.svh
/*
 Register offsets, field positions, reset values and timing figures
 of the LED flash sequencer. Definitions only; included by lfs_pkg.sv.
*/
`ifndef LFS_PARAMS_SVH
`define LFS_PARAMS_SVH
`define LFS_CLK_PS 4000
`define LFS_STEP_MS 8
`define LFS_SLOT_MS 64
`define LFS_STEP_CYC ((`LFS_STEP_MS * 1000000) / (`LFS_CLK_PS / 1000))
`define LFS_STEPS_PER_SLOT (`LFS_SLOT_MS / `LFS_STEP_MS)
`define LFS_PWM_DIV 250
`define LFS_PWM_FULL 5'h1F
`define LFS_CUR_MAX 4'h9
`define LFS_OFF_PIN_CFG 8'h00
`define LFS_OFF_LED_EN 8'h01
`define LFS_OFF_RAMP_UP 8'h02
`define LFS_OFF_RAMP_DN 8'h03
`define LFS_OFF_STATUS 8'h04
`define LFS_OFF_CH_BASE 8'h20
`define LFS_CH_STRIDE 8
`define LFS_F_CUR 0
`define LFS_F_ON 1
`define LFS_F_T1 2
`define LFS_F_TP 6
`define LFS_F_PWM 7
`define LFS_B_RAMP_EN 4
`define LFS_B_SEQ_EN 3
`define LFS_RESET_VAL 8'h00
`define LFS_UNMAPPED 8'hFF
`endif

// >>> hw/lfs_pkg.sv
/*
 Types of the LED flash sequencer. Assumes lfs_params.svh is on the
 include path.
*/
`include "lfs_params.svh"
package lfs_pkg;
	typedef enum logic [1:0] {
		LFS_PH_UP = 2'b00,
		LFS_PH_ON = 2'b01,
		LFS_PH_DOWN = 2'b10,
		LFS_PH_OFF = 2'b11
	} lfs_phase_t;
	typedef logic [2:0] lfs_slot_t;
endpackage

// >>> hw/lfs_top.sv
/*
 Three-channel LED current-sink controller with flash sequencer,
 PWM dimming and a plain register port.
 Assumes one 250 MHz clock, pins resolved by the surrounding pad ring,
 and a register master that never issues read and write together.
*/
`timescale 1ns/1ns
`include "lfs_params.svh"
//Behaviour
// - a pin whose config bit is 1 becomes an LED current sink
// - enabled sink current is PWM'd by a 5-bit duty field over sequencing
// - duty code all ones gives continuous conduction
// - 4-bit current code per channel; code 0100 means 10 mA
// - dc current per channel spans 2 mA to 20 mA
// - a channel sinks only when its enable bit is 1
// - a per-channel sequencer enable runs a flash sequence instead of steady on
// - four slot durations per channel, 0 to 127 units of 64 ms
// - per-channel period slot, 0 to 127 units of 64 ms, own register
// - ramp up and down step times 0 to 31 units of 8 ms, separate registers
// - each slot: ramp up, on-time, ramp down
// - ramp step times shared, all else per channel
// - ramp disabled: current jumps straight to the level
// - ramp enabled: in sequencer mode current steps up and down by the shared slopes
module lfs_top import lfs_pkg::*; #(
	parameter int STEP_CYC = `LFS_STEP_CYC, // cycles per 8 ms step
	parameter int PWM_DIV = `LFS_PWM_DIV, // cycles per pwm count
	parameter int NCH = 3 // channels
) (
	input wire logic mclk_i, // 250 MHz clock
	input wire logic rst_i, // async reset, active high
	input wire logic [7:0] addr_i, // register address
	input wire logic [7:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [7:0] rdata_o, // read data, cycle after rd_i
	input wire logic [NCH-1:0] gp_out_i, // general-purpose output value
	input wire logic [NCH-1:0] gp_oe_i, // general-purpose output enable
	output logic [NCH-1:0] gp_in_o, // synchronised pin level
	input wire logic [NCH-1:0] pin_i, // pad input
	output logic [NCH-1:0] pin_o, // pad output value
	output logic [NCH-1:0] pin_oe_o, // pad output enable
	output logic [NCH*4-1:0] cur_code_o // sink current code per channel
);
	// software-visible settings
	logic [NCH-1:0] pin_led_sel; // 1 = pin is an LED sink
	logic [NCH-1:0] ch_en;
	logic [NCH-1:0] seq_en;
	logic [4:0] ramp_up;
	logic [4:0] ramp_dn;
	logic [7:0] ch_reg [NCH][8];

	// per-channel outputs kept for the status register
	logic [NCH-1:0] sink_on;
	logic [NCH-1:0] in_on_phase;

	// pad synchroniser and shared time bases
	logic [NCH-1:0] pin_s1;
	logic [NCH-1:0] pin_s2;
	logic [31:0] step_cnt;
	logic step_tick;
	logic [15:0] pwm_div_cnt;
	logic [4:0] pwm_cnt;

	// register port decode
	logic ch_hit;
	logic [1:0] ch_idx;
	logic [2:0] ch_fld;

	// channel window: 0x20 + 8*ch + field
	assign ch_idx = addr_i[4:3];
	assign ch_fld = addr_i[2:0];
	assign ch_hit = (addr_i[7:5] == `LFS_OFF_CH_BASE >> 5) && (ch_idx < NCH[1:0]);

	// global control registers
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_led_sel <= '0;
			ch_en <= '0;
			seq_en <= '0;
			ramp_up <= 5'h00;
			ramp_dn <= 5'h00;
		end else if (wr_i) begin
			case (addr_i)
				`LFS_OFF_PIN_CFG: pin_led_sel <= wdata_i[NCH-1:0];
				`LFS_OFF_LED_EN: begin
					ch_en <= wdata_i[NCH-1:0];
					seq_en <= wdata_i[`LFS_B_SEQ_EN +: NCH];
				end
				`LFS_OFF_RAMP_UP: ramp_up <= wdata_i[4:0];
				`LFS_OFF_RAMP_DN: ramp_dn <= wdata_i[4:0];
				default: ;
			endcase
		end
	end

	// per-channel settings: current, on-time, four slots, period, duty
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int c = 0; c < NCH; c++) begin
				for (int f = 0; f < 8; f++) begin
					ch_reg[c][f] <= `LFS_RESET_VAL;
				end
			end
		end else if (wr_i && ch_hit) begin
			ch_reg[ch_idx][ch_fld] <= wdata_i;
		end
	end

	// read port; unmapped addresses read all ones
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			if (ch_hit) begin
				rdata_o <= ch_reg[ch_idx][ch_fld];
			end else begin
				case (addr_i)
					`LFS_OFF_PIN_CFG: rdata_o <= {5'h00, pin_led_sel};
					`LFS_OFF_LED_EN: rdata_o <= {2'h0, seq_en, ch_en};
					`LFS_OFF_RAMP_UP: rdata_o <= {3'h0, ramp_up};
					`LFS_OFF_RAMP_DN: rdata_o <= {3'h0, ramp_dn};
					`LFS_OFF_STATUS: rdata_o <= {2'h0, in_on_phase, sink_on};
					default: rdata_o <= `LFS_UNMAPPED;
				endcase
			end
		end
	end

	// 8 ms step divider; everything in the sequencer counts these steps
	// a wide counter keeps the step exact at the full clock rate, no prescaler drift
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			step_cnt <= 32'h0000_0000;
			step_tick <= 1'b0;
		end else if (step_cnt >= 32'(STEP_CYC - 1)) begin
			step_cnt <= 32'h0000_0000;
			step_tick <= 1'b1;
		end else begin
			step_cnt <= step_cnt + 32'h0000_0001;
			step_tick <= 1'b0;
		end
	end

	// pwm time base: 31 counts per period, shared by all channels
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pwm_div_cnt <= 16'h0000;
			pwm_cnt <= 5'h00;
		end else if (pwm_div_cnt >= 16'(PWM_DIV - 1)) begin
			pwm_div_cnt <= 16'h0000;
			pwm_cnt <= (pwm_cnt >= `LFS_PWM_FULL - 5'h01) ? 5'h00 : pwm_cnt + 5'h01;
		end else begin
			pwm_div_cnt <= pwm_div_cnt + 16'h0001;
		end
	end

	// pad input synchroniser for the general-purpose path
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			pin_s1 <= pin_i;
			pin_s2 <= pin_s1;
		end
	end
	assign gp_in_o = pin_s2;

	for (genvar c = 0; c < NCH; c++) begin : g_ch
		// sequencer state
		lfs_phase_t phase;
		lfs_slot_t slot;
		logic [9:0] slot_cnt;
		logic [9:0] ph_cnt;
		logic [3:0] lvl;

		// settings decoded from this channel's registers
		logic [3:0] target;
		logic ramp_en;
		logic [9:0] slot_len;
		logic [9:0] on_len;
		logic slot_end;

		// output shaping
		logic [3:0] drive;
		logic pwm_pass;
		logic [4:0] duty;

		// codes above 9 would exceed 20 mA, so they are clamped
		assign target = (ch_reg[c][`LFS_F_CUR][3:0] > `LFS_CUR_MAX) ?
			`LFS_CUR_MAX : ch_reg[c][`LFS_F_CUR][3:0];
		assign ramp_en = ch_reg[c][`LFS_F_CUR][`LFS_B_RAMP_EN];
		assign duty = ch_reg[c][`LFS_F_PWM][4:0];
		// slots 0..3 are T1..T4, slot 4 is the period slot, in 8 ms steps
		assign slot_len = (slot == 3'd4) ?
			{ch_reg[c][`LFS_F_TP][6:0], 3'b000} :
			{ch_reg[c][`LFS_F_T1 + 32'(slot)][6:0], 3'b000};
		assign on_len = {ch_reg[c][`LFS_F_ON][6:0], 3'b000};
		assign slot_end = (slot_cnt + 10'h001 >= slot_len);

		// sequencer: slot walk plus ramp/on/ramp shape within each slot
		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				phase <= LFS_PH_UP;
				slot <= 3'd0;
				slot_cnt <= 10'h000;
				ph_cnt <= 10'h000;
				lvl <= 4'h0;
			end else if (!ch_en[c] || !seq_en[c]) begin
				// idle or steady mode restarts at the first slot
				// without a ramp the slot opens in the on phase, so lit time is the on-time
				phase <= ramp_en ? LFS_PH_UP : LFS_PH_ON;
				slot <= 3'd0;
				slot_cnt <= 10'h000;
				ph_cnt <= 10'h000;
				lvl <= ramp_en ? 4'h0 : target;
			end else if (step_tick) begin
				if (slot_end) begin
					// an overrun of the slot cuts the shape short
					slot <= (slot == 3'd4) ? 3'd0 : slot + 3'd1;
					slot_cnt <= 10'h000;
					ph_cnt <= 10'h000;
					// a jump to the level skips the ramp phase entirely
					phase <= ramp_en ? LFS_PH_UP : LFS_PH_ON;
					lvl <= ramp_en ? 4'h0 : target;
				end else begin
					slot_cnt <= slot_cnt + 10'h001;
					case (phase)
						LFS_PH_UP: begin
							if (lvl >= target) begin
								phase <= LFS_PH_ON;
								ph_cnt <= 10'h000;
								lvl <= target;
							end else if (ph_cnt >= {5'h00, ramp_up}) begin
								lvl <= lvl + 4'h1;
								// the on time starts as the level is reached, not a step later
								if (lvl + 4'h1 >= target) begin
									phase <= LFS_PH_ON;
								end
								ph_cnt <= 10'h000;
							end else begin
								ph_cnt <= ph_cnt + 10'h001;
							end
						end
						LFS_PH_ON: begin
							lvl <= target;
							if (ph_cnt + 10'h001 >= on_len) begin
								phase <= ramp_en ? LFS_PH_DOWN : LFS_PH_OFF;
								lvl <= ramp_en ? target : 4'h0;
								ph_cnt <= 10'h000;
							end else begin
								ph_cnt <= ph_cnt + 10'h001;
							end
						end
						LFS_PH_DOWN: begin
							if (lvl == 4'h0) begin
								phase <= LFS_PH_OFF;
							end else if (ph_cnt >= {5'h00, ramp_dn}) begin
								lvl <= lvl - 4'h1;
								ph_cnt <= 10'h000;
							end else begin
								ph_cnt <= ph_cnt + 10'h001;
							end
						end
						LFS_PH_OFF: lvl <= 4'h0;
						default: phase <= LFS_PH_OFF;
					endcase
				end
			end
		end

		// steady mode uses the level directly; disabled channel is dark
		assign drive = !ch_en[c] ? 4'h0 : (seq_en[c] ? lvl : target);
		// full duty bypasses the compare so the sink never blinks off
		assign pwm_pass = (duty == `LFS_PWM_FULL) || (pwm_cnt < duty);

		// sink and pad drivers are flopped so the pins never glitch
		always_ff @(posedge mclk_i or posedge rst_i) begin
			if (rst_i) begin
				sink_on[c] <= 1'b0;
				in_on_phase[c] <= 1'b0;
				cur_code_o[c*4 +: 4] <= 4'h0;
				pin_o[c] <= 1'b0;
				pin_oe_o[c] <= 1'b0;
			end else begin
				sink_on[c] <= pin_led_sel[c] && (drive != 4'h0) && pwm_pass;
				in_on_phase[c] <= ch_en[c] && seq_en[c] && (phase == LFS_PH_ON);
				cur_code_o[c*4 +: 4] <= pin_led_sel[c] ? drive : 4'h0;
				if (pin_led_sel[c]) begin
					// a sink only pulls low; it never drives the pin high
					pin_o[c] <= 1'b0;
					pin_oe_o[c] <= (drive != 4'h0) && pwm_pass;
				end else begin
					// plain io passes through one flop, the same delay as the sink path
					pin_o[c] <= gp_out_i[c];
					pin_oe_o[c] <= gp_oe_i[c];
				end
			end
		end
	end
endmodule

// >>> testbench/lfs_led_model.sv
/*
 LED loads on the three shared pins.
 Assumes each pin is pulled up through its LED to the supply.
*/
`timescale 1ns/1ns
module lfs_led_model (
	input wire logic [2:0] pin_o_i, // pad value from design
	input wire logic [2:0] pin_oe_i, // pad drive or sink on
	output logic [2:0] pin_i_o // resolved pad level
);
	// a conducting sink pulls low; a released pin floats up, never holds its last value
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_i_o[i] = pin_oe_i[i] ? pin_o_i[i] : 1'b1;
		end
	end
endmodule

// >>> testbench/lfs_props.sv
/*
 Port checker of the LED sequencer.
 Assumes it is bound to lfs_top with three channels.
*/
`timescale 1ns/1ns
module lfs_props (
	input wire logic mclk_i, // clock
	input wire logic rst_i, // reset
	input wire logic [7:0] addr_i, // address
	input wire logic [7:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	input wire logic [7:0] rdata_o, // read data
	input wire logic [2:0] gp_out_i, // gp value
	input wire logic [2:0] gp_oe_i, // gp enable
	input wire logic [2:0] pin_o, // pad value
	input wire logic [2:0] pin_oe_o, // pad enable
	input wire logic [11:0] cur_code_o // current codes
);
	logic [7:0] cfg_h;
	logic [7:0] en_h;
	logic [7:0] up_h;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// shadows of written settings, so outputs can be tied to their cause
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_h <= 8'h00;
			en_h <= 8'h00;
			up_h <= 8'h00;
		end else if (wr_i) begin
			if (addr_i == 8'h00) cfg_h <= wdata_i;
			if (addr_i == 8'h01) en_h <= wdata_i;
			if (addr_i == 8'h02) up_h <= wdata_i;
		end
	end
	sequence s_led_dis;
		cfg_h[2:0] == 3'h7 && en_h[0] ##1 !en_h[0];
	endsequence
	property p_led_low;
		cfg_h[2:0] == 3'h7 && $past(cfg_h[2:0]) == 3'h7 |-> pin_o == 3'h0;
	endproperty
	a_led_low: assert property (p_led_low) else $error("led pin driven high");
	property p_gp_pass;
		cfg_h[2:0] == 3'h0 && $past(cfg_h[2:0]) == 3'h0 |->
			pin_o == $past(gp_out_i) && pin_oe_o == $past(gp_oe_i);
	endproperty
	a_gp_pass: assert property (p_gp_pass) else $error("gp value not passed");
	property p_dis_off;
		s_led_dis |-> ##2 !pin_oe_o[0] && cur_code_o[3:0] == 4'h0;
	endproperty
	a_dis_off: assert property (p_dis_off) else $error("sink left on");
	property p_clamp;
		cur_code_o[3:0] <= 4'h9 && cur_code_o[7:4] <= 4'h9 && cur_code_o[11:8] <= 4'h9;
	endproperty
	a_clamp: assert property (p_clamp) else $error("current above range");
	property p_en_read;
		rd_i && addr_i == 8'h01 |=> rdata_o == {2'h0, en_h[5:0]};
	endproperty
	a_en_read: assert property (p_en_read) else $error("enable readback");
	property p_up_read;
		rd_i && addr_i == 8'h02 |=> rdata_o[4:0] == up_h[4:0];
	endproperty
	a_up_read: assert property (p_up_read) else $error("ramp readback");
	property p_unmapped;
		rd_i && addr_i inside {[8'h05:8'h1F]} |=> rdata_o == 8'hFF;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	property p_hold;
		!rd_i |=> $stable(rdata_o);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind lfs_top lfs_props u_lfs_props (.mclk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .gp_out_i, .gp_oe_i, .pin_o, .pin_oe_o, .cur_code_o);

// >>> testbench/lfs_top_test.sv
/*
 Self-checking bench of lfs_top with LED loads.
 Assumes a 10-cycle step and a 1-cycle pwm count.
*/
`timescale 1ns/1ns
module lfs_top_test;
	logic mclk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic [7:0] rdata_o;
	logic [2:0] gp_out_i = 3'h0;
	logic [2:0] gp_oe_i = 3'h0;
	logic [2:0] gp_in_o, pin_i, pin_o, pin_oe_o;
	logic [11:0] cur_code_o;
	logic [31:0] rs = 32'h0000000A;
	int miscompares = 0;
	int cmp_count = 0;
	int n, mid;
	initial forever #2 mclk_i = ~mclk_i;
	lfs_top #(.STEP_CYC(10), .PWM_DIV(1), .NCH(3)) u_lfs_top (.mclk_i, .rst_i, .addr_i,
		.wdata_i, .wr_i, .rd_i, .rdata_o, .gp_out_i, .gp_oe_i, .gp_in_o, .pin_i, .pin_o,
		.pin_oe_o, .cur_code_o);
	lfs_led_model u_lfs_led_model (.pin_o_i(pin_o), .pin_oe_i(pin_oe_o), .pin_i_o(pin_i));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 cmp({8'h00, rdata_o}, {8'h00, e});
		@(posedge mclk_i);
	endtask
	// counts sink-on cycles of channel 0 and cycles at an intermediate level
	task automatic watch(input int cyc);
		n = 0;
		mid = 0;
		repeat (cyc) begin
			@(posedge mclk_i);
			#1 n += pin_oe_o[0];
			mid += int'(cur_code_o[3:0] inside {4'h1, 4'h2, 4'h3});
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// the whole run is some 3200 cycles; this leaves ample margin
	initial begin
		#100000;
		miscompares++;
		end_of_test();
	end
	initial begin
		repeat (16) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		for (int i = 0; i < 8; i++) begin
			rs = xs(rs);
			wr(8'h28 + 8'(i), rs[7:0]);
			rd(8'h28 + 8'(i), rs[7:0]);
		end
		wr(8'h02, 8'h1F);
		rd(8'h02, 8'h1F);
		rd(8'h10, 8'hFF);
		$display("register test done");
		// plain io mode, pads come back through the synchroniser
		wr(8'h00, 8'h00);
		repeat (4) begin
			@(posedge mclk_i);
			rs = xs(rs);
			gp_out_i <= rs[2:0];
			gp_oe_i <= rs[5:3];
			repeat (4) @(posedge mclk_i);
			#1 cmp({13'h0000, gp_in_o}, {13'h0000, rs[2:0] & rs[5:3] | ~rs[5:3]});
		end
		$display("io test done");
		// all three pins switched together, as software must
		wr(8'h00, 8'h07);
		wr(8'h20, 8'h04);
		wr(8'h27, 8'h1F);
		wr(8'h30, 8'h0F);
		wr(8'h2F, 8'h1F);
		wr(8'h01, 8'h05);
		repeat (4) @(posedge mclk_i);
		watch(100);
		cmp(n[15:0], 16'h0064);
		cmp({12'h000, cur_code_o[3:0]}, 16'h0004);
		cmp({12'h000, cur_code_o[11:8]}, 16'h0009);
		cmp({15'h0000, pin_oe_o[1]}, 16'h0000);
		cmp({15'h0000, gp_in_o[0]}, 16'h0000);
		rd(8'h01, 8'h05);
		rd(8'h04, 8'h01);
		wr(8'h27, 8'h08);
		repeat (4) @(posedge mclk_i);
		watch(310);
		cmp(n[15:0], 16'h0050);
		wr(8'h01, 8'h04);
		$display("steady test done");
		// slots of 24 steps and 8 steps on leave room for the ramps below
		wr(8'h27, 8'h1F);
		wr(8'h02, 8'h00);
		wr(8'h03, 8'h00);
		wr(8'h21, 8'h01);
		for (int i = 2; i < 7; i++) wr(8'h20 + 8'(i), 8'h03);
		wr(8'h01, 8'h09);
		repeat (8) @(posedge mclk_i);
		watch(1200);
		cmp(n[15:0], 16'h0190);
		cmp(mid[15:0], 16'h0000);
		// wait out the slot that was running when the ramp was switched on
		wr(8'h20, 8'h14);
		repeat (260) @(posedge mclk_i);
		watch(1200);
		cmp(mid[15:0], 16'h012C);
		cmp(n[15:0], 16'h02EE);
		$display("sequence test done");
		end_of_test();
	end
endmodule
